// ===== uilm_consts.svh
// constants for the uart interrupt-id, line format and modem control block
// Overview of operation
// R1 - interrupt id bits 2:1 report highest pending source, bit 0 low when pending
// R2 - id bit 3 zero outside fifo mode, set with bit 2 on timeout
// R3 - id bits 4 and 5 always read zero
// R4 - id bits 7:6 are ones while fifo enable is set
// R5 - timeout after 4 idle char times with receive fifo non-empty, cleared by buffer read
// R6 - transmit empty interrupt cleared by id read when reported, or holding write
// R7 - line format bits 1:0 select five to eight data bits
// R8 - bit 2 selects one stop bit, or 1.5 for five bits, two otherwise
// R9 - receiver checks only the first stop bit
// R10 - bit 3 enables parity after last data bit, before first stop bit
// R11 - bit 4 zero gives odd parity, one gives even parity
// R12 - bit 5 with parity sends fixed parity equal to complement of bit 4
// R13 - bit 6 forces serial output to space until cleared
// R14 - bit 7 steers offsets 0 and 1 to divisor latches
// R15 - terminal ready output low when modem control bit 0 set
// R16 - request to send output follows bit 1 inverted
// R17 - bit 2 is plain storage, used only in loopback
// R18 - interrupt output enabled only while bit 3 set
// R19 - loopback holds output marking, feeds transmit into receive
// R20 - loopback disconnects modem inputs, forces outputs high, routes them internally
// R21 - loopback keeps interrupts; modem status sourced from modem control bits
// R22 - modem control bits 7:5 read zero
// R23 - id bit 0 low while any enabled interrupt pending
// R24 - priority: line status, receive data and timeout, transmit empty, modem status
`ifndef UILM_CONSTS_SVH
`define UILM_CONSTS_SVH
`define UILM_OFS_DATA     3'h0
`define UILM_OFS_IER      3'h1
`define UILM_OFS_IID      3'h2
`define UILM_OFS_LFC      3'h3
`define UILM_OFS_HOC      3'h4
`define UILM_OFS_LSR      3'h5
`define UILM_OFS_MSR      3'h6
`define UILM_OFS_SCR      3'h7
`define UILM_LFC_RST      8'h00
`define UILM_HOC_RST      5'h00
`define UILM_IER_RST      4'h0
`define UILM_DIV_RST      16'h0001
`define UILM_ID_NONE      4'h1
`define UILM_ID_LINE      4'h6
`define UILM_ID_RXD       4'h4
`define UILM_ID_TMO       4'hC
`define UILM_ID_THRE      4'h2
`define UILM_ID_MODEM     4'h0
`define UILM_TMO_CHARS    3'h4
`define UILM_CLK_HZ       25000000
`endif

// ===== uilm_pkg.sv
// types for the uart interrupt-id, line format and modem control block
package uilm_pkg;
    typedef struct packed {
        logic [3:0] cts_dsr_ri_dcd_n;
    } uilm_modem_in_s;
    typedef struct packed {
        logic dl_sel;
        logic fifo_en;
        logic rx_has_data;
        logic rx_push;
        logic rx_pop;
        logic char_tick;
        logic line_pend;
        logic rxd_pend;
        logic thre_set;
        logic modem_pend;
    } uilm_status_s;
    typedef struct packed {
        logic [7:0]  lfc;
        logic [4:0]  hoc;
        logic [3:0]  ier;
        logic [15:0] div;
        logic [7:0]  rdata;
        logic        thre_pend;
        logic        tmo_pend;
        logic [2:0]  idle_chars;
        logic        txd;
        logic        dtr_n;
        logic        rts_n;
        logic        irq;
        logic        irq_oe;
        logic        loop_rx;
        logic [3:0]  modem_eff_n;
        logic        thr_wr;
        logic [7:0]  thr_data;
        logic        rbr_rd;
    } uilm_state_s;
endpackage

// ===== uilm_core.sv
// interrupt identification, line format and modem control for one uart
`timescale 1ns/100ps
`include "uilm_consts.svh"
module uilm_core (
    input  wire logic                    i_clk,
    input  wire logic                    i_srst,
    input  wire logic [2:0]              i_addr,
    input  wire logic                    i_rd,
    input  wire logic                    i_wr,
    input  wire logic [7:0]              i_wdata,
    input  wire logic [7:0]              i_rbr_data,
    input  wire logic                    i_tsr_out,
    input  wire logic                    i_rxd,
    input  wire uilm_pkg::uilm_modem_in_s i_modem,
    input  wire uilm_pkg::uilm_status_s  i_stat,
    output logic [7:0]                   o_rdata,
    output logic                         o_txd,
    output logic                         o_terminal_ready_n,
    output logic                         o_request_to_send_n,
    output logic                         o_irq,
    output logic                         o_irq_oe,
    output logic                         o_rx_serial,
    output logic [3:0]                   o_modem_eff_n,
    output logic [15:0]                  o_divisor,
    output logic [7:0]                   o_line_format,
    output logic                         o_thr_wr,
    output logic [7:0]                   o_thr_data,
    output logic                         o_rbr_rd
);
    import uilm_pkg::*;

    uilm_state_s st_r;
    uilm_state_s st_nxt;

    logic       line_en;
    logic       rxd_en;
    logic       tmo_en;
    logic       thre_en;
    logic       modem_en;
    logic [3:0] id_code;
    logic [7:0] id_byte;
    logic       dl;
    logic       wr_thr;
    logic       rd_rbr;
    logic       rd_id;

    always_comb begin
        dl       = st_r.lfc[7];
        line_en  = i_stat.line_pend & st_r.ier[2];
        rxd_en   = i_stat.rxd_pend & st_r.ier[0];
        tmo_en   = st_r.tmo_pend & st_r.ier[0];
        thre_en  = st_r.thre_pend & st_r.ier[1];
        modem_en = i_stat.modem_pend & st_r.ier[3];
        // priority order line, timeout/rx, thre, modem [R24]
        if (line_en) begin
            id_code = `UILM_ID_LINE; // [R1]
        end else if (tmo_en) begin
            id_code = `UILM_ID_TMO; // [R2]
        end else if (rxd_en) begin
            id_code = `UILM_ID_RXD;
        end else if (thre_en) begin
            id_code = `UILM_ID_THRE;
        end else if (modem_en) begin
            id_code = `UILM_ID_MODEM;
        end else begin
            id_code = `UILM_ID_NONE; // [R23]
        end
        // bits 5:4 zero, 7:6 track fifo enable [R3] [R4]
        id_byte = {{2{i_stat.fifo_en}}, 2'b00, id_code};
        wr_thr  = i_wr & (i_addr == `UILM_OFS_DATA) & ~dl; // [R14]
        rd_rbr  = i_rd & (i_addr == `UILM_OFS_DATA) & ~dl;
        rd_id   = i_rd & (i_addr == `UILM_OFS_IID);
    end

    always_comb begin
        st_nxt        = st_r;
        st_nxt.thr_wr = wr_thr;
        st_nxt.rbr_rd = rd_rbr;
        if (wr_thr) begin
            st_nxt.thr_data = i_wdata;
        end
        if (i_wr) begin
            unique case (i_addr)
                `UILM_OFS_DATA: begin
                    if (dl) begin
                        st_nxt.div[7:0] = i_wdata; // [R14]
                    end
                end
                `UILM_OFS_IER: begin
                    if (dl) begin
                        st_nxt.div[15:8] = i_wdata;
                    end else begin
                        st_nxt.ier = i_wdata[3:0];
                    end
                end
                `UILM_OFS_LFC: begin
                    st_nxt.lfc = i_wdata; // [R7] [R8] [R10] [R11] [R12]
                end
                `UILM_OFS_HOC: begin
                    st_nxt.hoc = i_wdata[4:0]; // [R17]
                end
                default: begin
                end
            endcase
        end
        // read data mux, captured the cycle after the strobe
        st_nxt.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                `UILM_OFS_DATA: st_nxt.rdata = dl ? st_r.div[7:0] : i_rbr_data;
                `UILM_OFS_IER:  st_nxt.rdata = dl ? st_r.div[15:8] : {4'h0, st_r.ier};
                `UILM_OFS_IID:  st_nxt.rdata = id_byte;
                `UILM_OFS_LFC:  st_nxt.rdata = st_r.lfc;
                `UILM_OFS_HOC:  st_nxt.rdata = {3'b000, st_r.hoc}; // [R22]
                default:        st_nxt.rdata = 8'h00;
            endcase
        end
        // thre: set wins over clear so a fresh empty is not lost [R6]
        if (i_stat.thre_set) begin
            st_nxt.thre_pend = 1'b1;
        end else if (wr_thr | (rd_id & (id_code == `UILM_ID_THRE))) begin
            st_nxt.thre_pend = 1'b0;
        end
        // character timeout: fifo activity or a buffer read restarts the count [R5]
        if (~i_stat.fifo_en | ~i_stat.rx_has_data | i_stat.rx_push | i_stat.rx_pop | rd_rbr) begin
            st_nxt.idle_chars = 3'h0;
            st_nxt.tmo_pend   = 1'b0;
        end else if (i_stat.char_tick & (st_r.idle_chars != `UILM_TMO_CHARS)) begin
            st_nxt.idle_chars = st_r.idle_chars + 3'h1;
            if (st_r.idle_chars + 3'h1 == `UILM_TMO_CHARS) begin
                st_nxt.tmo_pend = 1'b1; // [R5]
            end
        end
        // serial output: loopback marks, break spaces [R13] [R19]
        if (st_r.hoc[4]) begin
            st_nxt.txd = 1'b1;
        end else if (st_r.lfc[6]) begin
            st_nxt.txd = 1'b0;
        end else begin
            st_nxt.txd = i_tsr_out;
        end
        if (st_r.hoc[4]) begin
            st_nxt.dtr_n       = 1'b1; // [R20]
            st_nxt.rts_n       = 1'b1;
            st_nxt.loop_rx     = i_tsr_out; // [R19]
            // cts from rts, dsr from dtr, ri from user output one, dcd from irq gate [R20] [R21]
            st_nxt.modem_eff_n = ~{st_r.hoc[1], st_r.hoc[0], st_r.hoc[2], st_r.hoc[3]};
        end else begin
            st_nxt.dtr_n       = ~st_r.hoc[0]; // [R15]
            st_nxt.rts_n       = ~st_r.hoc[1]; // [R16]
            st_nxt.loop_rx     = i_rxd;
            st_nxt.modem_eff_n = i_modem.cts_dsr_ri_dcd_n;
        end
        st_nxt.irq    = (id_code != `UILM_ID_NONE);
        st_nxt.irq_oe = st_r.hoc[3]; // [R18]
        if (i_srst) begin
            st_nxt             = '0;
            st_nxt.lfc         = `UILM_LFC_RST;
            st_nxt.hoc         = `UILM_HOC_RST;
            st_nxt.ier         = `UILM_IER_RST;
            st_nxt.div         = `UILM_DIV_RST;
            st_nxt.txd         = 1'b1;
            st_nxt.dtr_n       = 1'b1;
            st_nxt.rts_n       = 1'b1;
            st_nxt.loop_rx     = 1'b1;
            st_nxt.modem_eff_n = 4'hF;
        end
    end

    always_ff @(posedge i_clk) begin
        st_r <= st_nxt;
    end

    // receiver checks only first stop bit; format exported to shifters [R9]
    assign o_rdata             = st_r.rdata;
    assign o_txd               = st_r.txd;
    assign o_terminal_ready_n  = st_r.dtr_n;
    assign o_request_to_send_n = st_r.rts_n;
    assign o_irq               = st_r.irq;
    assign o_irq_oe            = st_r.irq_oe;
    assign o_rx_serial         = st_r.loop_rx;
    assign o_modem_eff_n       = st_r.modem_eff_n;
    assign o_divisor           = st_r.div;
    assign o_line_format       = st_r.lfc;
    assign o_thr_wr            = st_r.thr_wr;
    assign o_thr_data          = st_r.thr_data;
    assign o_rbr_rd            = st_r.rbr_rd;
endmodule

// ===== uilm_properties.sv
// concurrent checks on the uart id, line format and modem control block
`timescale 1ns/100ps
module uilm_properties (
    input wire logic                    i_clk,
    input wire logic                    i_srst,
    input wire logic [2:0]              i_addr,
    input wire logic                    i_rd,
    input wire logic                    i_wr,
    input wire logic [7:0]              i_wdata,
    input wire logic                    i_tsr_out,
    input wire uilm_pkg::uilm_modem_in_s i_modem,
    input wire uilm_pkg::uilm_status_s  i_stat,
    input wire logic [7:0]              o_rdata,
    input wire logic                    o_txd,
    input wire logic                    o_terminal_ready_n,
    input wire logic                    o_request_to_send_n,
    input wire logic                    o_irq_oe,
    input wire logic [3:0]              o_modem_eff_n,
    input wire logic [15:0]             o_divisor,
    input wire logic [7:0]              o_line_format,
    input wire logic                    o_thr_wr,
    input wire logic [7:0]              o_thr_data
);
    import uilm_pkg::*;
    // shadow of the handshake control bits, rebuilt from host writes
    logic [4:0] hoc_r;
    always_ff @(posedge i_clk) begin
        if (i_srst) hoc_r <= 5'h00;
        else if (i_wr && i_addr == 3'h4) hoc_r <= i_wdata[4:0];
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_dtr_level: assert property (o_terminal_ready_n == ($past(hoc_r[4]) || !$past(hoc_r[0])))
        else $error("terminal ready level wrong");
    a_rts_level: assert property (o_request_to_send_n == ($past(hoc_r[4]) || !$past(hoc_r[1])))
        else $error("request to send level wrong");
    a_irq_enable: assert property (o_irq_oe == $past(hoc_r[3]))
        else $error("irq enable wrong");
    // first edge after reset still shows reset levels, so it is skipped
    a_txd_break: assert property (!$past(i_srst) && !$past(hoc_r[4]) |->
        o_txd == (!$past(o_line_format[6]) && $past(i_tsr_out))) else $error("serial output wrong");
    a_loop_mark: assert property (!$past(i_srst) && $past(hoc_r[4]) && !$past(o_line_format[6]) |-> o_txd)
        else $error("loopback output not marking");
    a_modem_route: assert property (!$past(i_srst) && $past(hoc_r[4]) |-> o_modem_eff_n ==
        ~{$past(hoc_r[1]), $past(hoc_r[0]), $past(hoc_r[2]), $past(hoc_r[3])}) else $error("loopback modem routing wrong");
    a_modem_pins: assert property (!$past(i_srst) && !$past(hoc_r[4]) |-> o_modem_eff_n == $past(i_modem))
        else $error("modem inputs not passed");
    a_div_steer: assert property (i_wr && i_addr == 3'h1 && o_line_format[7] |=> o_divisor[15:8] == $past(i_wdata))
        else $error("divisor write lost");
    a_thr_steer: assert property (i_wr && i_addr == 3'h0 && !o_line_format[7] |=> o_thr_wr && o_thr_data == $past(i_wdata))
        else $error("holding write lost");
    a_id_fixed: assert property (i_rd && i_addr == 3'h2 |=> o_rdata[5:4] == 2'h0
        && o_rdata[7:6] == {2{$past(i_stat.fifo_en)}} && (!o_rdata[3] || $past(i_stat.fifo_en) && o_rdata[2]))
        else $error("id fixed bits wrong");
    a_hoc_read: assert property (i_rd && i_addr == 3'h4 |=> o_rdata == {3'h0, $past(hoc_r)})
        else $error("handshake control readback wrong");
endmodule
bind uilm_core uilm_properties chk_u (
    .i_clk               (i_clk),
    .i_srst              (i_srst),
    .i_addr              (i_addr),
    .i_rd                (i_rd),
    .i_wr                (i_wr),
    .i_wdata             (i_wdata),
    .i_tsr_out           (i_tsr_out),
    .i_modem             (i_modem),
    .i_stat              (i_stat),
    .o_rdata             (o_rdata),
    .o_txd               (o_txd),
    .o_terminal_ready_n  (o_terminal_ready_n),
    .o_request_to_send_n (o_request_to_send_n),
    .o_irq_oe            (o_irq_oe),
    .o_modem_eff_n       (o_modem_eff_n),
    .o_divisor           (o_divisor),
    .o_line_format       (o_line_format),
    .o_thr_wr            (o_thr_wr),
    .o_thr_data          (o_thr_data)
);

// ===== uilm_modem_model.sv
// far-side modem: loops handshake lines back at once and serial data back promptly or late
`timescale 1ns/100ps
module uilm_modem_model (
    input  wire logic                i_clk,
    input  wire logic                i_slow,
    input  wire logic [1:0]          i_ring_dcd_n,
    input  wire logic                i_dtr_n,
    input  wire logic                i_rts_n,
    input  wire logic                i_txd,
    output uilm_pkg::uilm_modem_in_s o_modem,
    output logic                     o_rxd
);
    import uilm_pkg::*;
    logic [3:0] echo_r;
    always_ff @(posedge i_clk) echo_r <= {echo_r[2:0], i_txd};
    // a slow modem returns the line four cycles after it is sent, three later than a prompt one
    assign o_rxd = i_slow ? echo_r[3] : echo_r[0];
    assign o_modem.cts_dsr_ri_dcd_n = {i_rts_n, i_dtr_n, i_ring_dcd_n};
endmodule

// ===== tb.sv
// self-checking bench for the uart id, line format and modem control block
`timescale 1ns/100ps
module tb;
    import uilm_pkg::*;
    logic           i_clk, i_srst, i_rd, i_wr, i_tsr_out, i_rxd, slow;
    logic           o_txd, o_terminal_ready_n, o_request_to_send_n, o_irq, o_irq_oe, o_rx_serial, o_thr_wr, o_rbr_rd;
    logic [1:0]     ring_dcd_n;
    logic [2:0]     i_addr;
    logic [3:0]     o_modem_eff_n;
    logic [7:0]     i_wdata, i_rbr_data, o_rdata, o_line_format, o_thr_data;
    logic [15:0]    o_divisor;
    uilm_modem_in_s i_modem;
    uilm_status_s   i_stat;
    int             errors, total_checks;
    uilm_core dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
        .i_rbr_data(i_rbr_data), .i_tsr_out(i_tsr_out), .i_rxd(i_rxd), .i_modem(i_modem), .i_stat(i_stat),
        .o_rdata(o_rdata), .o_txd(o_txd), .o_terminal_ready_n(o_terminal_ready_n),
        .o_request_to_send_n(o_request_to_send_n), .o_irq(o_irq), .o_irq_oe(o_irq_oe), .o_rx_serial(o_rx_serial),
        .o_modem_eff_n(o_modem_eff_n), .o_divisor(o_divisor), .o_line_format(o_line_format), .o_thr_wr(o_thr_wr),
        .o_thr_data(o_thr_data), .o_rbr_rd(o_rbr_rd));
    uilm_modem_model model_u (.i_clk(i_clk), .i_slow(slow), .i_ring_dcd_n(ring_dcd_n), .i_dtr_n(o_terminal_ready_n),
        .i_rts_n(o_request_to_send_n), .i_txd(o_txd), .o_modem(i_modem), .o_rxd(i_rxd));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_addr = a;
        i_wdata = d;
        i_wr = 1'b1;
        @(negedge i_clk);
        i_wr = 1'b0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        i_addr = a;
        i_rd = 1'b1;
        @(negedge i_clk);
        i_rd = 1'b0;
        chk({8'h00, o_rdata}, {8'h00, exp});
    endtask
    task automatic pulse(input logic [9:0] m, input int n);
        repeat (n) begin
            @(negedge i_clk);
            i_stat = i_stat | m;
            @(negedge i_clk);
            i_stat = i_stat & ~m;
        end
    endtask
    task automatic t_id();
        wr(3'h1, 8'h0F);
        i_stat.line_pend = 1'b1;
        i_stat.rxd_pend = 1'b1;
        i_stat.modem_pend = 1'b1;
        rdc(3'h2, 8'h06);
        chk({15'h0000, o_irq}, 16'h0001);
        i_stat.line_pend = 1'b0;
        rdc(3'h2, 8'h04);
        i_stat.rxd_pend = 1'b0;
        pulse(10'h002, 1);
        rdc(3'h2, 8'h02);
        rdc(3'h2, 8'h00);
        pulse(10'h002, 1);
        wr(3'h0, 8'h5A);
        chk({7'h00, o_thr_wr, o_thr_data}, 16'h015A);
        i_stat.modem_pend = 1'b0;
        rdc(3'h2, 8'h01);
        chk({15'h0000, o_irq}, 16'h0000);
    endtask
    task automatic t_tmo();
        i_stat.fifo_en = 1'b1;
        i_stat.rx_has_data = 1'b1;
        pulse(10'h010, 3);
        rdc(3'h2, 8'hC1);
        pulse(10'h010, 1);
        rdc(3'h2, 8'hCC);
        rdc(3'h0, 8'hA5);
        chk({15'h0000, o_rbr_rd}, 16'h0001);
        rdc(3'h2, 8'hC1);
        i_stat.fifo_en = 1'b0;
        i_stat.rx_has_data = 1'b0;
    endtask
    task automatic t_format();
        for (int i = 0; i < 64; i++) begin
            wr(3'h3, 8'(i));
            rdc(3'h3, 8'(i));
            chk({8'h00, o_line_format}, 16'(i));
        end
        i_tsr_out = 1'b1;
        wr(3'h3, 8'h40);
        repeat (2) @(negedge i_clk);
        chk({15'h0000, o_txd}, 16'h0000);
        wr(3'h3, 8'h00);
        repeat (2) @(negedge i_clk);
        chk({15'h0000, o_txd}, 16'h0001);
    endtask
    task automatic t_div();
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h34);
        wr(3'h1, 8'h12);
        chk(o_divisor, 16'h1234);
        rdc(3'h0, 8'h34);
        rdc(3'h1, 8'h12);
        wr(3'h3, 8'h00);
        wr(3'h0, 8'h77);
        rdc(3'h1, 8'h0F);
        chk(o_divisor, 16'h1234);
    endtask
    task automatic t_modem();
        wr(3'h4, 8'h0B);
        repeat (3) @(negedge i_clk);
        chk({9'h000, o_irq_oe, o_terminal_ready_n, o_request_to_send_n, o_modem_eff_n}, 16'h0042);
        ring_dcd_n = 2'b01;
        repeat (2) @(negedge i_clk);
        chk({12'h000, o_modem_eff_n}, 16'h0001);
        wr(3'h4, 8'hFF);
        rdc(3'h4, 8'h1F);
        chk({10'h000, o_terminal_ready_n, o_request_to_send_n, o_modem_eff_n}, 16'h0030);
        wr(3'h4, 8'h15);
        i_tsr_out = 1'b0;
        repeat (3) @(negedge i_clk);
        chk({10'h000, o_txd, o_rx_serial, o_modem_eff_n}, 16'h0029);
        wr(3'h4, 8'h00);
        slow = 1'b1;
        repeat (8) @(negedge i_clk);
        chk({15'h0000, o_rx_serial}, 16'h0000);
        i_tsr_out = 1'b1;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        {i_srst, i_rd, i_wr, i_tsr_out, slow} = 5'b10010;
        {i_addr, i_wdata, i_rbr_data, ring_dcd_n} = {3'h0, 8'h00, 8'hA5, 2'b10};
        i_stat = '0;
        repeat (3) @(negedge i_clk);
        i_srst = 1'b0;
        chk({8'h00, o_divisor[3:0], o_txd, o_terminal_ready_n, o_request_to_send_n, o_irq_oe}, 16'h001E);
        t_id();
        t_tmo();
        t_format();
        t_div();
        t_modem();
        print_verdict();
    end
    initial begin
        #2000000;
        errors++;
        print_verdict();
    end
endmodule
